//--- dv/ddr2_ctl_model.sv
// Purpose: Memory controller model on the DRAM clock, command and data pins.
// Assumes: Commands change on the falling clock, stable across the rise.
// Notes: Data lines show the inverse of the last bit once a burst ends.
module ddr2_ctl_model
    import ddr2_ocd_pkg::*;
(
    // Pins.
    output logic ck,
    output cmd_type cmd,
    output logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ck = 1'b0;
        cmd = {5'h1f, 2'h0, 12'h000};
        dq = 8'h00;
    end
    always #62.5 ck = ~ck;
    // One command per clock, then deselect with clock enable kept.
    task automatic issue(input logic [4:0] ctl, input logic [1:0] ba, input logic [11:0] a);
        @(negedge ck) cmd <= {ctl, ba, a};
        @(negedge ck) cmd.cs_n <= 1'b1;
    endtask : issue
    // Write in adjust mode with write latency two; same code on all lines, fixed order.
    task automatic adjust(input logic [3:0] code);
        issue(5'h14, 2'h0, 12'h000);
        dq = {8{code[3]}};
        repeat (3) @(ck);
        for (int i = 2; i >= 0; i--) begin
            #31 dq = {8{code[i]}};
            @(ck);
        end
        #31 dq = ~dq;
    endtask : adjust
endmodule : ddr2_ctl_model

//--- dv/ddr2_emr_ocd_calibration_tb.sv
// Purpose: Self-checking bench for mode registers, DLL control and calibration.
// Assumes: APB with zero wait states; DRAM pins from the controller model.
// Notes: A fixed settle follows each command, as filters delay every pin.
module ddr2_emr_ocd_calibration_tb import ddr2_ocd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ck, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, rdqs_out, rdqs_oe, dm_enable;
    logic reduced_strength, ocd_default_active, dll_enable, dll_reset, dll_locked, ext_srf_rate, self_refresh;
    logic [7:0] dq_in, dq_out, dq_oe;
    logic [3:0] pu = STEP_RESET, pd = STEP_RESET;
    cmd_type cmd;
    strength_type drive_strength;
    int bad_count = 0, compares = 0, cycles = 0;
    always #5 mclk = ~mclk;
    ddr2_ctl_model i_ctl (.ck(ck), .cmd(cmd), .dq(dq_in));
    ddr2_emr_ocd_calibration i_dut (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic mrs(input logic [1:0] ba, input logic [11:0] a);
        i_ctl.issue(5'h10, ba, a);
        repeat (6) @(posedge mclk);
    endtask : mrs
    task automatic step(input logic [3:0] code, input int du, input int dd);
        i_ctl.adjust(code);
        repeat (8) @(posedge mclk);
        pu = (du > 0 && pu == STEP_MAX) || (du < 0 && pu == 4'h0) ? pu : 4'(int'(pu) + du);
        pd = (dd > 0 && pd == STEP_MAX) || (dd < 0 && pd == 4'h0) ? pd : 4'(int'(pd) + dd);
        check(32'(drive_strength), {24'h0, pu, pd});
    endtask : step
    task automatic t_init;
        apb(1'b0, REG_CTRL, 32'h0);
        check(rd, {24'h0, CTRL_RESET});
        apb(1'b0, 12'h0fc, 32'h0);
        check({rd[30:0], err}, 32'h1);
        mrs(BA_EMR2, 12'h080);
        mrs(BA_EMR3, MODE_RESET);
        mrs(BA_EMR1, MODE_RESET);
        mrs(BA_MR, 12'h132);
        check(32'({ext_srf_rate, dll_enable}), 32'h3);
        apb(1'b0, REG_EMR2, 32'h0);
        check(rd, 32'h80);
    endtask : t_init
    task automatic t_drive;
        for (int m = 0; m < 2; m++) begin
            mrs(BA_EMR1, {~m[0], 1'b0, m[0] ? OCD_DRIVE_LOW : OCD_DRIVE_HIGH, 7'h00});
            check({8'h0, dq_oe, dq_out, 2'h0, dqs_n_oe, dqs_oe, dqs_out, dqs_n_out, rdqs_oe, dm_enable},
                {8'h0, 8'hff, m[0] ? 8'h00 : 8'hff, 3'h1, 1'b1, ~m[0], m[0], ~m[0], m[0]});
            mrs(BA_EMR1, MODE_RESET);
            check(32'({dq_oe, dqs_oe, rdqs_oe}), 32'h0);
        end
    endtask : t_drive
    task automatic t_adjust;
        logic [3:0] codes [11] = '{ADJ_NOP, ADJ_PU_UP, ADJ_PU_DN, ADJ_PD_UP, ADJ_PD_DN, ADJ_BOTH_UP,
            ADJ_PU_DN_PD_UP, ADJ_PU_UP_PD_DN, ADJ_BOTH_DN, 4'h3, 4'hf};
        int du [11] = '{0, 1, -1, 0, 0, 1, -1, 1, -1, 0, 0};
        int dd [11] = '{0, 0, 0, 1, -1, 1, 1, -1, -1, 0, 0};
        mrs(BA_EMR1, {2'h0, OCD_ADJUST, 7'h00});
        for (int i = 0; i < 11; i++) step(codes[i], du[i], dd[i]);
        for (int i = 0; i < 24; i++) step(i < 8 ? ADJ_BOTH_UP : ADJ_BOTH_DN, i < 8 ? 1 : -1, i < 8 ? 1 : -1);
        mrs(BA_EMR1, MODE_RESET);
        check(32'(drive_strength), 32'h00);
    endtask : t_adjust
    task automatic t_default;
        apb(1'b1, REG_CTRL, 32'h35);
        mrs(BA_EMR1, {2'h0, OCD_DEFAULT, 7'h00});
        check(32'({ocd_default_active, drive_strength}), 32'h153);
        mrs(BA_EMR1, MODE_RESET);
        check(32'({ocd_default_active, drive_strength}), 32'h153);
        mrs(BA_EMR1, 12'h002);
        check(32'({reduced_strength, ocd_default_active}), 32'h2);
        mrs(BA_EMR1, MODE_RESET);
    endtask : t_default
    task automatic t_srf;
        i_ctl.issue(5'h01, 2'h0, 12'h000);
        repeat (6) @(posedge mclk);
        check(32'({self_refresh, dll_enable}), 32'h2);
        i_ctl.issue(5'h1f, 2'h0, 12'h000);
        repeat (6) @(posedge mclk);
        check(32'({self_refresh, dll_enable, dll_locked}), 32'h2);
        repeat (190) @(posedge ck);
        check(32'(dll_locked), 32'h0);
        repeat (15) @(posedge ck);
        check(32'(dll_locked), 32'h1);
    endtask : t_srf
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        t_init;
        t_drive;
        t_adjust;
        t_default;
        t_srf;
        complete_run;
    end
endmodule : ddr2_emr_ocd_calibration_tb
bind ddr2_emr_ocd_calibration ddr2_ocd_checker i_chk (.*);

//--- dv/ddr2_ocd_checker_properties.sv
// Purpose: Concurrent checks on driver outputs, strength counters and DLL controls.
// Assumes: One clock domain, disabled while nrst is low.
// Notes: Drive delays are judged by the bench.
module ddr2_ocd_checker
    import ddr2_ocd_pkg::*;
(
    // Clock, reset and drivers.
    input wire logic mclk, nrst, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, rdqs_out, rdqs_oe,
    input wire logic [7:0] dq_out, dq_oe,
    // Controls.
    input wire logic dm_enable, reduced_strength, ocd_default_active, dll_enable, dll_reset, self_refresh,
    input wire strength_type drive_strength
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_rdqs; rdqs_oe |-> !dm_enable && rdqs_out == dqs_out; endproperty
    a_rdqs: assert property (p_rdqs) else $error("Read strobe wrong.");
    property p_pair; dqs_oe && dqs_n_oe |-> dqs_n_out != dqs_out; endproperty
    a_pair: assert property (p_pair) else $error("Strobe pair not inverse.");
    property p_level; dqs_oe && dq_oe[0] |-> dq_out == {8{dqs_out}}; endproperty
    a_level: assert property (p_level) else $error("Data level differs from strobe.");
    property p_all; dqs_oe |-> dq_oe == 8'hff; endproperty
    a_all: assert property (p_all) else $error("Not all data drivers on.");
    // A default load may jump anywhere, so cycles where ocd_default_active rises are exempt from the saturation checks.
    property p_pu_sat; $past(drive_strength.pull_up) == STEP_MAX && !$rose(ocd_default_active)
        |-> drive_strength.pull_up != 4'h0; endproperty
    a_pu_sat: assert property (p_pu_sat) else $error("Pull-up wrapped.");
    property p_pd_sat; $past(drive_strength.pull_down) == 4'h0 && !$rose(ocd_default_active)
        |-> drive_strength.pull_down != STEP_MAX; endproperty
    a_pd_sat: assert property (p_pd_sat) else $error("Pull-down wrapped.");
    property p_sr_dll; self_refresh |-> !dll_enable; endproperty
    a_sr_dll: assert property (p_sr_dll) else $error("DLL on in self refresh.");
    property p_sr_exit; $fell(self_refresh) |-> ##[0:2] dll_reset; endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("No DLL reset on exit.");
    property p_reduced; reduced_strength |-> !ocd_default_active; endproperty
    a_reduced: assert property (p_reduced) else $error("Default at reduced strength.");
    c_drive: cover property ($rose(dqs_oe));
    c_sr: cover property ($rose(self_refresh));
    c_step: cover property ($changed(drive_strength));
endmodule : ddr2_ocd_checker

//--- inc/ddr2_ocd_pkg.sv
// Purpose: Shared constants and carrier types for the DRAM mode register and driver calibration block.
// Assumes: System clock of 100 MHz; DRAM pins sampled on that clock.
// Notes: All offsets, field positions, codes and timing counts live here.

package ddr2_ocd_pkg;

    // ************************************************************
    // Command pins and strength carriers.
    // ************************************************************
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [11:0] addr;
    } cmd_type;

    typedef struct packed {
        logic [3:0] pull_up;
        logic [3:0] pull_down;
    } strength_type;

    // ************************************************************
    // Bank selects and mode register fields.
    // ************************************************************
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam logic [1:0] BA_EMR3 = 2'h3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_DLL_RESET = 8;
    localparam int E1_DLL_OFF = 0;
    localparam int E1_REDUCED = 1;
    localparam int E1_AL_LSB = 3;
    localparam int E1_OCD_LSB = 7;
    localparam int E1_DQSN_OFF = 10;
    localparam int E1_RDQS_EN = 11;
    localparam int E2_EXT_SRF = 7;
    localparam logic [11:0] MODE_RESET = 12'h000;

    // ************************************************************
    // Calibration control and adjust codes.
    // ************************************************************
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DRIVE_HIGH = 3'h1;
    localparam logic [2:0] OCD_DRIVE_LOW = 3'h2;
    localparam logic [2:0] OCD_ADJUST = 3'h4;
    localparam logic [2:0] OCD_DEFAULT = 3'h7;
    localparam logic [3:0] ADJ_NOP = 4'h0;
    localparam logic [3:0] ADJ_PU_UP = 4'h1;
    localparam logic [3:0] ADJ_PU_DN = 4'h2;
    localparam logic [3:0] ADJ_PD_UP = 4'h4;
    localparam logic [3:0] ADJ_PD_DN = 4'h8;
    localparam logic [3:0] ADJ_BOTH_UP = 4'h5;
    localparam logic [3:0] ADJ_PU_DN_PD_UP = 4'h6;
    localparam logic [3:0] ADJ_PU_UP_PD_DN = 4'h9;
    localparam logic [3:0] ADJ_BOTH_DN = 4'ha;
    localparam logic [3:0] STEP_MAX = 4'hf;
    localparam logic [3:0] STEP_RESET = 4'h8;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TOIT_NS = 12;
    localparam int TOIT_CYCLES = (TOIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DLL_LOCK_CK = 8'hc8;

    // ************************************************************
    // Register map and status fields.
    // ************************************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_STRENGTH = 12'h008;
    localparam logic [11:0] REG_MR = 12'h00c;
    localparam logic [11:0] REG_EMR1 = 12'h010;
    localparam logic [11:0] REG_EMR2 = 12'h014;
    localparam logic [11:0] REG_EMR3 = 12'h018;
    localparam logic [7:0] CTRL_RESET = 8'h88;
    localparam int ST_DRIVE_ON = 3;
    localparam int ST_ADJ_BUSY = 4;
    localparam int ST_ADJ_USED = 5;
    localparam int ST_DEFAULT = 6;
    localparam int ST_SELF_REF = 7;
    localparam int ST_DLL_EN = 8;
    localparam int ST_DLL_LOCK = 9;

endpackage : ddr2_ocd_pkg

//--- rtl/ddr2_emr_ocd_calibration.sv
// Purpose: Extended mode registers, DLL control and driver impedance calibration of the DRAM.
// Assumes: DRAM clock, command pins and DQ arrive asynchronously and are filtered here.
// Notes: Software sees the mode registers and calibration state over APB.

module ddr2_emr_ocd_calibration
    import ddr2_ocd_pkg::*;
(
    // System.
    input wire logic mclk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // DRAM clock, command and data pins.
    input wire logic ck,
    input wire cmd_type cmd,
    input wire logic [7:0] dq_in,
    // Output drivers.
    output logic [7:0] dq_out,
    output logic [7:0] dq_oe,
    output logic dqs_out,
    output logic dqs_oe,
    output logic dqs_n_out,
    output logic dqs_n_oe,
    output logic rdqs_out,
    output logic rdqs_oe,
    // Driver and core controls.
    output logic dm_enable,
    output strength_type drive_strength,
    output logic reduced_strength,
    output logic ocd_default_active,
    output logic dll_enable,
    output logic dll_reset,
    output logic dll_locked,
    output logic ext_srf_rate,
    output logic self_refresh
);

    // ************************************************************
    // Adjust decode.
    // ************************************************************
    // Returns {pull-up up, pull-up down, pull-down up, pull-down down}.
    function automatic logic [3:0] adjust_steps(input logic [3:0] code);
        logic [3:0] steps;
        case (code)
            ADJ_PU_UP: steps = 4'h8;
            ADJ_PU_DN: steps = 4'h4;
            ADJ_PD_UP: steps = 4'h2;
            ADJ_PD_DN: steps = 4'h1;
            ADJ_BOTH_UP: steps = 4'ha;
            ADJ_PU_DN_PD_UP: steps = 4'h6;
            ADJ_PU_UP_PD_DN: steps = 4'h9;
            ADJ_BOTH_DN: steps = 4'h5;
            default: steps = 4'h0;
        endcase
        return steps;
    endfunction : adjust_steps

    // ************************************************************
    // Pin filters.
    // ************************************************************
    // A change is accepted only when the second and third stages agree.
    logic [2:0] ck_sync;
    logic ck_q;
    logic ck_prev;
    cmd_type cmd_s1;
    cmd_type cmd_s2;
    cmd_type cmd_s3;
    cmd_type cmd_q;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;
    logic [7:0] dq_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ck_sync <= 3'h0;
            cmd_s1 <= '0;
            cmd_s2 <= '0;
            cmd_s3 <= '0;
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            dq_s3 <= 8'h00;
        end else begin
            ck_sync <= {ck_sync[1:0], ck};
            cmd_s1 <= cmd;
            cmd_s2 <= cmd_s1;
            cmd_s3 <= cmd_s2;
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ck_q <= 1'b0;
            ck_prev <= 1'b0;
            cmd_q <= '0;
            dq_q <= 8'h00;
        end else begin
            ck_prev <= ck_q;
            if (ck_sync[1] == ck_sync[2]) begin
                ck_q <= ck_sync[2];
            end
            if (cmd_s2 == cmd_s3) begin
                cmd_q <= cmd_s3;
            end
            if (dq_s2 == dq_s3) begin
                dq_q <= dq_s3;
            end
        end
    end

    // ************************************************************
    // Command decode.
    // ************************************************************
    wire ck_rise = ck_q & ~ck_prev;
    wire ck_edge = ck_q ^ ck_prev;
    wire cmd_low3 = ~cmd_q.cs_n & ~cmd_q.ras_n & ~cmd_q.cas_n;
    wire cmd_active = ck_rise & cmd_q.cke;
    wire mode_set = cmd_active & cmd_low3 & ~cmd_q.we_n;
    wire write_cmd = cmd_active & ~cmd_q.cs_n & cmd_q.ras_n & ~cmd_q.cas_n & ~cmd_q.we_n;
    wire set_mr = mode_set && cmd_q.ba == BA_MR;
    wire set_emr1 = mode_set && cmd_q.ba == BA_EMR1;
    wire set_emr2 = mode_set && cmd_q.ba == BA_EMR2;
    wire set_emr3 = mode_set && cmd_q.ba == BA_EMR3;
    wire srf_entry = ck_rise & ~cmd_q.cke & cmd_low3 & cmd_q.we_n & ~self_refresh;
    wire srf_exit = ck_rise & cmd_q.cke & self_refresh;

    logic [11:0] mr;
    logic [11:0] emr1;
    logic [11:0] emr2;
    logic [11:0] emr3;

    // Contents are not defined by the DRAM after power-up; zero is used here.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mr <= MODE_RESET;
            emr1 <= MODE_RESET;
            emr2 <= MODE_RESET;
            emr3 <= MODE_RESET;
            self_refresh <= 1'b0;
        end else begin
            if (set_mr) mr <= cmd_q.addr;
            if (set_emr1) emr1 <= cmd_q.addr;
            if (set_emr2) emr2 <= cmd_q.addr;
            if (set_emr3) emr3 <= cmd_q.addr;
            if (srf_entry) begin
                self_refresh <= 1'b1;
            end else if (srf_exit) begin
                self_refresh <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Field decode.
    // ************************************************************
    wire [2:0] ocd_mode = emr1[E1_OCD_LSB +: 3];
    wire [2:0] add_latency = emr1[E1_AL_LSB +: 3];
    wire [2:0] cas_latency = mr[MR_CL_LSB +: 3];
    wire [3:0] write_latency = 4'({1'b0, add_latency} + {1'b0, cas_latency} - 4'h1);
    wire rdqs_enabled = emr1[E1_RDQS_EN];
    wire dqsn_enabled = ~emr1[E1_DQSN_OFF];
    wire drive_target = ocd_mode == OCD_DRIVE_HIGH || ocd_mode == OCD_DRIVE_LOW;
    wire default_load = set_emr1 && cmd_q.addr[E1_OCD_LSB +: 3] == OCD_DEFAULT;

    assign reduced_strength = emr1[E1_REDUCED];
    assign dll_enable = ~emr1[E1_DLL_OFF] & ~self_refresh;
    assign ext_srf_rate = emr2[E2_EXT_SRF];

    // ************************************************************
    // DLL reset and lock count.
    // ************************************************************
    logic [7:0] lock_count;
    wire next_dll_reset = (set_mr & cmd_q.addr[MR_DLL_RESET]) | srf_exit;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dll_reset <= 1'b0;
            lock_count <= 8'h00;
        end else begin
            dll_reset <= next_dll_reset;
            if (!dll_enable || next_dll_reset) begin
                lock_count <= 8'h00;
            end else if (ck_rise && lock_count != DLL_LOCK_CK) begin
                lock_count <= lock_count + 8'h01;
            end
        end
    end

    // Tells the core that a read may now meet its access timing.
    assign dll_locked = dll_enable && lock_count == DLL_LOCK_CK;

    // ************************************************************
    // Adjust code capture.
    // ************************************************************
    typedef enum logic [1:0] {ADJ_IDLE, ADJ_WAIT, ADJ_BITS} adj_state_type;
    adj_state_type adj_state;
    logic [3:0] wait_count;
    logic [1:0] bit_index;
    logic [3:0] code_shift;
    logic code_valid;
    logic adjust_used;
    logic default_loaded;

    // Only DQ0 is sampled, since every data line carries the same code.
    wire [3:0] next_code = {code_shift[2:0], dq_q[0]};
    wire in_adjust = ocd_mode == OCD_ADJUST;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            adj_state <= ADJ_IDLE;
            wait_count <= 4'h0;
            bit_index <= 2'h0;
            code_shift <= 4'h0;
            code_valid <= 1'b0;
        end else begin
            code_valid <= 1'b0;
            case (adj_state)
                ADJ_IDLE: begin
                    if (write_cmd && in_adjust) begin
                        wait_count <= write_latency;
                        adj_state <= ADJ_WAIT;
                    end
                end
                ADJ_WAIT: begin
                    if (!in_adjust) begin
                        adj_state <= ADJ_IDLE;
                    end else if (ck_rise) begin
                        wait_count <= wait_count - 4'h1;
                        if (wait_count <= 4'h1) begin
                            code_shift <= next_code;
                            bit_index <= 2'h1;
                            adj_state <= ADJ_BITS;
                        end
                    end
                end
                ADJ_BITS: begin
                    // Bits follow on both clock edges in fixed order.
                    if (!in_adjust) begin
                        adj_state <= ADJ_IDLE;
                    end else if (ck_edge) begin
                        code_shift <= next_code;
                        bit_index <= bit_index + 2'h1;
                        if (bit_index == 2'h3) begin
                            code_valid <= 1'b1;
                            adj_state <= ADJ_IDLE;
                        end
                    end
                end
                default: begin
                    adj_state <= ADJ_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Strength counters.
    // ************************************************************
    logic [7:0] ctrl;
    // Steps are withheld at reduced strength, where calibration has no meaning.
    wire [3:0] steps = (code_valid && !reduced_strength) ? adjust_steps(code_shift) : 4'h0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            adjust_used <= 1'b0;
            default_loaded <= 1'b0;
        end else if (default_load) begin
            adjust_used <= 1'b0;
            default_loaded <= 1'b1;
        end else if (code_valid) begin
            adjust_used <= 1'b1;
        end
    end

    assign ocd_default_active = default_loaded & ~adjust_used & ~reduced_strength;

    // Both counters feed every data and strobe driver alike.
    ocd_step_counter pull_up_counter (
        .mclk(mclk),
        .nrst(nrst),
        .load(default_load),
        .load_value(ctrl[3:0]),
        .step_up(steps[3]),
        .step_down(steps[2]),
        .value(drive_strength.pull_up)
    );

    ocd_step_counter pull_down_counter (
        .mclk(mclk),
        .nrst(nrst),
        .load(default_load),
        .load_value(ctrl[7:4]),
        .step_up(steps[1]),
        .step_down(steps[0]),
        .value(drive_strength.pull_down)
    );

    // ************************************************************
    // Drive modes.
    // ************************************************************
    logic drive_on;
    logic drive_high;
    logic [3:0] toit_count;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            drive_on <= 1'b0;
            drive_high <= 1'b0;
            toit_count <= 4'h0;
        end else begin
            if (drive_target) drive_high <= ocd_mode == OCD_DRIVE_HIGH;
            if (drive_target == drive_on) begin
                toit_count <= 4'h0;
            end else if (toit_count == 4'(TOIT_CYCLES - 1)) begin
                drive_on <= drive_target;
                toit_count <= 4'h0;
            end else begin
                toit_count <= toit_count + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dq_out <= 8'h00;
            dq_oe <= 8'h00;
            dqs_out <= 1'b0;
            dqs_oe <= 1'b0;
            dqs_n_out <= 1'b0;
            dqs_n_oe <= 1'b0;
            rdqs_out <= 1'b0;
            rdqs_oe <= 1'b0;
            dm_enable <= 1'b1;
        end else begin
            // Registered beside the strobe enable, so the mask never reopens while the strobe still drives.
            dm_enable <= ~rdqs_enabled;
            dq_out <= {8{drive_high}};
            dq_oe <= {8{drive_on}};
            dqs_out <= drive_high;
            dqs_oe <= drive_on;
            dqs_n_out <= ~drive_high;
            dqs_n_oe <= drive_on & dqsn_enabled;
            rdqs_out <= drive_high;
            rdqs_oe <= drive_on & rdqs_enabled;
        end
    end

    // ************************************************************
    // APB registers.
    // ************************************************************
    wire setup = psel & ~penable;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit = hit_ctrl || paddr == REG_STATUS || paddr == REG_STRENGTH || paddr == REG_MR ||
               paddr == REG_EMR1 || paddr == REG_EMR2 || paddr == REG_EMR3;
    logic [31:0] status;
    logic [31:0] read_mux;
    logic addr_err;

    always_comb begin
        status = 32'h0;
        status[2:0] = ocd_mode;
        status[ST_DRIVE_ON] = drive_on;
        status[ST_ADJ_BUSY] = adj_state != ADJ_IDLE;
        status[ST_ADJ_USED] = adjust_used;
        status[ST_DEFAULT] = ocd_default_active;
        status[ST_SELF_REF] = self_refresh;
        status[ST_DLL_EN] = dll_enable;
        status[ST_DLL_LOCK] = dll_locked;
        case (paddr)
            REG_CTRL: read_mux = {24'h0, ctrl};
            REG_STATUS: read_mux = status;
            REG_STRENGTH: read_mux = {24'h0, drive_strength};
            REG_MR: read_mux = {20'h0, mr};
            REG_EMR1: read_mux = {20'h0, emr1};
            REG_EMR2: read_mux = {20'h0, emr2};
            REG_EMR3: read_mux = {20'h0, emr3};
            default: read_mux = 32'h0;
        endcase
    end

    // Read data is caught in the setup cycle so the access phase needs no wait.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
            addr_err <= 1'b0;
            ctrl <= CTRL_RESET;
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h0 : read_mux;
                addr_err <= ~hit;
            end
            if (psel && penable && pwrite && hit_ctrl) ctrl <= pwdata[7:0];
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & addr_err;

endmodule : ddr2_emr_ocd_calibration

//--- rtl/ocd_step_counter.sv
// Purpose: One saturating 16-step driver strength counter.
// Assumes: Step requests are single-cycle pulses on mclk.
// Notes: A load has priority over a step.

module ocd_step_counter
    import ddr2_ocd_pkg::*;
(
    // System.
    input wire logic mclk,
    input wire logic nrst,
    // Control.
    input wire logic load,
    input wire logic [3:0] load_value,
    input wire logic step_up,
    input wire logic step_down,
    // Result.
    output logic [3:0] value
);

    logic [3:0] next_value;

    // Steps past either end are dropped rather than wrapped.
    assign next_value = load ? load_value :
                        (step_up && value != STEP_MAX) ? value + 4'h1 :
                        (step_down && value != 4'h0) ? value - 4'h1 : value;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            value <= STEP_RESET;
        end else begin
            value <= next_value;
        end
    end

endmodule : ocd_step_counter
